/* File: rtl/bcs_regs.svh */
/*
 * Timing constants and encodings for the battery charge sequencer.
 * Assumes a 50 MHz system clock; timer figures are for nominal 1nF timing caps.
 */
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH

// System clock rate in Hz.
`define BCS_CLK_HZ 50000000
// Prescaled tick period in milliseconds; all timers count this tick.
`define BCS_TICK_MS 1
`define BCS_TICK_CYCLES ((`BCS_CLK_HZ / 1000) * `BCS_TICK_MS)
// Timeouts in tenths of a minute at the nominal capacitor setting.
`define BCS_PREQUAL_DMIN 75
`define BCS_FAST_DMIN 900
`define BCS_FULL_DMIN 900
`define BCS_TOPOFF_DMIN 450
// Ticks per tenth of a minute.
`define BCS_TICKS_PER_DMIN (6000 / `BCS_TICK_MS)
// Temperature sample rate in millihertz and the resulting period in ticks.
`define BCS_SAMPLE_MHZ 1120
`define BCS_SAMPLE_TICKS (1000000 / (`BCS_SAMPLE_MHZ * `BCS_TICK_MS))
// Length of one sense phase (hot or cold test) in ticks, charge paused meanwhile.
`define BCS_SENSE_TICKS 2
// Cell strap codes.
`define BCS_STRAP_GND 2'h0
`define BCS_STRAP_FLOAT 2'h1
`define BCS_STRAP_REF 2'h2
`define BCS_STRAP_REG 2'h3
// Timer capacitor setting that yields the nominal period (units of 0.1 nF).
`define BCS_CAP_NOMINAL 8'h0A

`endif

/* File: rtl/bcs_pkg.sv */
/*
 * Types shared by the battery charge sequencer modules.
 * Assumes bcs_regs.svh supplies the numeric constants.
 */
package bcs_pkg;
    // Charge states, Gray coded along reset-prequal-fast-full-topoff-done.
    typedef enum logic [2:0] {
        BCS_RESET   = 3'h0,
        BCS_PREQUAL = 3'h1,
        BCS_FAST    = 3'h3,
        BCS_FULL    = 3'h2,
        BCS_TOPOFF  = 3'h6,
        BCS_DONE    = 3'h7,
        BCS_FAULT   = 3'h5
    } bcs_state_t;

    // Charge current command to the analog loops.
    typedef enum logic [1:0] {
        BCS_I_OFF   = 2'h0,
        BCS_I_TENTH = 2'h1,
        BCS_I_FULL  = 2'h2,
        BCS_I_CV    = 2'h3
    } bcs_current_t;
endpackage : bcs_pkg

/* File: rtl/bcs_timer_if.sv */
/*
 * Carrier between the sequencer and one safety timer.
 * Assumes a single clock domain; the tick is a one-cycle enable.
 */
`timescale 1ns/1ps
interface bcs_timer_if;
    logic clear;
    logic run;
    logic [31:0] limit;
    logic expired;
    modport ctrl (output clear, output run, output limit, input expired);
    modport tmr (input clear, input run, input limit, output expired);
endinterface : bcs_timer_if

/* File: rtl/bcs_timer.sv */
/*
 * One safety timer: zeroes on clear, else counts prescaled ticks while run is high up to its limit and holds otherwise.
 * Assumes tick is a one-cycle enable pulse on clk_sys.
 */
`timescale 1ns/1ps
module bcs_timer (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic tick,
    bcs_timer_if.tmr t
);
    logic [31:0] count;
    logic [31:0] next_count;

    // Holding the count while run is low lets a suspended charge resume where it left.
    always_comb begin
        next_count = count;
        if (t.clear) begin
            next_count = 32'h0000_0000;
        end else if (t.run && tick && !t.expired) begin
            next_count = count + 32'h0000_0001; // [RULE17]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count <= 32'h0000_0000;
        end else begin
            count <= next_count;
        end
    end

    assign t.expired = (count >= t.limit);
endmodule : bcs_timer

/* File: rtl/bcs_sequencer.sv */
/*
 * Charge sequencer for a stand-alone battery charger: safety timers, temperature
 * sampling with suspend and resume, open-drain indicators, latched fault,
 * shutdown, dropout shutoff and cell-count strap decode.
 * Assumes all inputs are synchronous to clk_sys and analog comparisons arrive as
 * levels from the analog front end.
 */
// What this block does
// [RULE1] Timer caps set prequal, full, topoff, fast limits.
// [RULE2] Fast-charge indicator on during constant-current phase.
// [RULE3] Full-charge indicator on during constant-voltage phase.
// [RULE4] Fault latches, stops charge until power or shutdown.
// [RULE5] Alternate hot and cold sense currents on thermistor.
// [RULE6] Sample temperature periodically, pausing charge meanwhile.
// [RULE7] Out-of-window temperature suspends charge and holds timers.
// [RULE8] Shutdown stops charge, switch off, divider off.
// [RULE9] Shutdown floats all three status outputs.
// [RULE10] Leaving shutdown resets timers, starts fresh cycle.
// [RULE11] Supply within 100mV of battery turns charger off.
// [RULE12] Decode strap: ground 1, float 2, ref 3, regulator 4.
// [RULE13] Prequal at tenth current; advance or fault on timeout.
// [RULE14] Fast charge to full at limit; fault on timeout.
// [RULE15] Full to topoff on low current or timeout.
// [RULE16] Done waits for recharge threshold, then resets.
// [RULE17] Timers count a common tick, scaled by setting.
// [RULE18] Topoff timer expiry enters done with zero current.
`timescale 1ns/1ps
`include "bcs_regs.svh"
module bcs_sequencer #(
    parameter int TICK_CYCLES = `BCS_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic shutdown_input,
    input wire logic dropout_detect,
    input wire logic battery_node_above_uv,
    input wire logic battery_node_at_reg,
    input wire logic battery_node_below_recharge,
    input wire logic battery_node_overvoltage,
    input wire logic current_below_term,
    input wire logic bias_ok,
    input wire logic therm_hot_trip,
    input wire logic therm_cold_trip,
    input wire logic [7:0] timer_cap_a,
    input wire logic [7:0] timer_cap_b,
    input wire logic [1:0] cell_strap,
    output logic fast_charge_indicator_o,
    output logic fast_charge_indicator_oe,
    output logic full_charge_indicator_o,
    output logic full_charge_indicator_oe,
    output logic fault_indicator_o,
    output logic fault_indicator_oe,
    output logic therm_hot_current_en,
    output logic therm_cold_current_en,
    output logic high_side_enable,
    output logic divider_enable,
    output bcs_pkg::bcs_current_t charge_current,
    output logic [2:0] cell_count,
    output bcs_pkg::bcs_state_t charge_state
);
    bcs_pkg::bcs_state_t state;
    bcs_pkg::bcs_state_t next_state;
    logic [31:0] prescale;
    logic [31:0] next_prescale;
    logic tick;
    logic [31:0] sample_cnt;
    logic [31:0] next_sample_cnt;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic hot_bad;
    logic next_hot_bad;
    logic temp_ok;
    logic next_temp_ok;
    logic [2:0] next_cell_count;
    logic fresh;
    logic charging;
    logic sensing;
    logic suspended;
    bcs_timer_if t_pre ();
    bcs_timer_if t_fast ();
    bcs_timer_if t_full ();
    bcs_timer_if t_top ();

    // One prescaled tick drives every timer and the sample scheduler.
    always_comb begin
        next_prescale = prescale + 32'h0000_0001;
        if (prescale == TICK_CYCLES - 1) begin
            next_prescale = 32'h0000_0000;
        end
    end
    assign tick = (prescale == TICK_CYCLES - 1);

    // Timer limits scale linearly with the capacitor setting; nominal cap gives nominal time.
    function automatic logic [31:0] bcs_limit(input logic [7:0] cap, input logic [31:0] dmin);
        logic [39:0] prod;
        prod = 40'(dmin) * 40'(`BCS_TICKS_PER_DMIN) * 40'(cap);
        return 32'(prod / 40'(`BCS_CAP_NOMINAL));
    endfunction : bcs_limit

    assign t_pre.limit = bcs_limit(timer_cap_a, 32'(`BCS_PREQUAL_DMIN)); // [RULE1]
    assign t_full.limit = bcs_limit(timer_cap_a, 32'(`BCS_FULL_DMIN)); // [RULE1]
    assign t_top.limit = bcs_limit(timer_cap_a, 32'(`BCS_TOPOFF_DMIN)); // [RULE1]
    assign t_fast.limit = bcs_limit(timer_cap_b, 32'(`BCS_FAST_DMIN)); // [RULE1]

    // Temperature sampler: idle, hot test, cold test. Charge pauses during tests.
    always_comb begin
        next_sample_cnt = sample_cnt;
        next_phase = phase;
        next_hot_bad = hot_bad;
        next_temp_ok = temp_ok;
        if (tick) begin
            next_sample_cnt = sample_cnt + 32'h0000_0001;
            if (phase == 2'h0 && sample_cnt >= 32'(`BCS_SAMPLE_TICKS) - 32'h0000_0001) begin
                next_phase = 2'h1; // [RULE6]
                next_sample_cnt = 32'h0000_0000;
            end else if (phase == 2'h1 && sample_cnt >= 32'(`BCS_SENSE_TICKS) - 32'h0000_0001) begin
                next_hot_bad = therm_hot_trip;
                next_phase = 2'h2; // [RULE5]
                next_sample_cnt = 32'h0000_0000;
            end else if (phase == 2'h2 && sample_cnt >= 32'(`BCS_SENSE_TICKS) - 32'h0000_0001) begin
                next_temp_ok = !hot_bad && !therm_cold_trip; // [RULE5]
                next_phase = 2'h0;
                next_sample_cnt = 32'h0000_0000;
            end
        end
    end
    assign therm_hot_current_en = shutdown_input && (phase == 2'h1); // [RULE5]
    assign therm_cold_current_en = shutdown_input && (phase == 2'h2); // [RULE5]
    assign sensing = (phase != 2'h0);

    // Cell count strap decode; the strap is re-read every cycle so a level is always valid.
    always_comb begin
        unique case (cell_strap)
            `BCS_STRAP_GND: next_cell_count = 3'h1; // [RULE12]
            `BCS_STRAP_FLOAT: next_cell_count = 3'h2; // [RULE12]
            `BCS_STRAP_REF: next_cell_count = 3'h3; // [RULE12]
            `BCS_STRAP_REG: next_cell_count = 3'h4; // [RULE12]
        endcase
    end

    assign charging = (state == bcs_pkg::BCS_PREQUAL) || (state == bcs_pkg::BCS_FAST) ||
                      (state == bcs_pkg::BCS_FULL) || (state == bcs_pkg::BCS_TOPOFF);
    assign suspended = !temp_ok; // [RULE7]

    // Timers run only in their own state with temperature in window.
    assign fresh = (state == bcs_pkg::BCS_RESET) || !shutdown_input; // [RULE10]
    assign t_pre.clear = fresh;
    assign t_fast.clear = fresh;
    assign t_full.clear = fresh;
    assign t_top.clear = fresh;
    assign t_pre.run = (state == bcs_pkg::BCS_PREQUAL) && !suspended; // [RULE7]
    assign t_fast.run = (state == bcs_pkg::BCS_FAST) && !suspended; // [RULE7]
    assign t_full.run = (state == bcs_pkg::BCS_FULL) && !suspended; // [RULE7]
    assign t_top.run = (state == bcs_pkg::BCS_TOPOFF) && !suspended; // [RULE7]

    bcs_timer u_pre (.clk_sys(clk_sys), .reset(reset), .tick(tick), .t(t_pre.tmr));
    bcs_timer u_fast (.clk_sys(clk_sys), .reset(reset), .tick(tick), .t(t_fast.tmr));
    bcs_timer u_full (.clk_sys(clk_sys), .reset(reset), .tick(tick), .t(t_full.tmr));
    bcs_timer u_top (.clk_sys(clk_sys), .reset(reset), .tick(tick), .t(t_top.tmr));

    // Charge state machine. Shutdown forces reset, which also clears a latched fault.
    always_comb begin
        next_state = state;
        if (!shutdown_input) begin
            next_state = bcs_pkg::BCS_RESET; // [RULE8] [RULE4] [RULE10]
        end else begin
            unique case (state)
                bcs_pkg::BCS_RESET: begin
                    if (bias_ok && !dropout_detect) begin
                        next_state = bcs_pkg::BCS_PREQUAL;
                    end
                end
                bcs_pkg::BCS_PREQUAL: begin
                    if (t_pre.expired) begin
                        next_state = bcs_pkg::BCS_FAULT; // [RULE13]
                    end else if (battery_node_above_uv && temp_ok) begin
                        next_state = bcs_pkg::BCS_FAST; // [RULE13]
                    end
                end
                bcs_pkg::BCS_FAST: begin
                    if (battery_node_at_reg) begin
                        next_state = bcs_pkg::BCS_FULL; // [RULE14]
                    end else if (t_fast.expired) begin
                        next_state = bcs_pkg::BCS_FAULT; // [RULE14]
                    end
                end
                bcs_pkg::BCS_FULL: begin
                    if ((current_below_term && !suspended) || t_full.expired) begin
                        next_state = bcs_pkg::BCS_TOPOFF; // [RULE15]
                    end
                end
                bcs_pkg::BCS_TOPOFF: begin
                    if (t_top.expired) begin
                        next_state = bcs_pkg::BCS_DONE; // [RULE18]
                    end
                end
                bcs_pkg::BCS_DONE: begin
                    if (battery_node_below_recharge) begin
                        next_state = bcs_pkg::BCS_RESET; // [RULE16]
                    end
                end
                bcs_pkg::BCS_FAULT: next_state = bcs_pkg::BCS_FAULT; // [RULE4]
                default: next_state = bcs_pkg::BCS_RESET;
            endcase
            // Dropout and overvoltage abort an active cycle back to reset.
            if (charging && (dropout_detect || battery_node_overvoltage)) begin
                next_state = bcs_pkg::BCS_RESET; // [RULE11]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= bcs_pkg::BCS_RESET;
            prescale <= 32'h0000_0000;
            sample_cnt <= 32'h0000_0000;
            phase <= 2'h0;
            hot_bad <= 1'b0;
            temp_ok <= 1'b1;
            cell_count <= 3'h1;
        end else begin
            state <= next_state;
            prescale <= next_prescale;
            sample_cnt <= next_sample_cnt;
            phase <= next_phase;
            hot_bad <= next_hot_bad;
            temp_ok <= next_temp_ok;
            cell_count <= next_cell_count;
        end
    end

    // Current command; zero when paused for sensing, suspended, dropped out or stopped.
    always_comb begin
        charge_current = bcs_pkg::BCS_I_OFF;
        if (shutdown_input && !dropout_detect && !sensing && !suspended) begin // [RULE6] [RULE11]
            unique case (state)
                bcs_pkg::BCS_PREQUAL: charge_current = bcs_pkg::BCS_I_TENTH; // [RULE13]
                bcs_pkg::BCS_FAST: charge_current = bcs_pkg::BCS_I_FULL;
                bcs_pkg::BCS_FULL: charge_current = bcs_pkg::BCS_I_CV;
                bcs_pkg::BCS_TOPOFF: charge_current = bcs_pkg::BCS_I_CV;
                default: charge_current = bcs_pkg::BCS_I_OFF; // [RULE18]
            endcase
        end
    end
    assign high_side_enable = (charge_current != bcs_pkg::BCS_I_OFF); // [RULE8]
    assign divider_enable = shutdown_input; // [RULE8]
    assign charge_state = state;

    // Open-drain indicators pull low when active; all float in shutdown.
    assign fast_charge_indicator_o = 1'b0;
    assign full_charge_indicator_o = 1'b0;
    assign fault_indicator_o = 1'b0;
    assign fast_charge_indicator_oe = shutdown_input && (state == bcs_pkg::BCS_FAST); // [RULE2] [RULE9]
    assign full_charge_indicator_oe = shutdown_input && (state == bcs_pkg::BCS_FULL); // [RULE3] [RULE9]
    assign fault_indicator_oe = shutdown_input && (state == bcs_pkg::BCS_FAULT); // [RULE4] [RULE9]
endmodule : bcs_sequencer

/* File: verif/bcs_sequencer_monitor.sv */
/* Port checker for the charge sequencer.
   Assumes it is bound to bcs_sequencer and sees one clock domain. */
`timescale 1ns/1ps
module bcs_sequencer_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic shutdown_input,
    input wire logic dropout_detect,
    input wire logic battery_node_at_reg,
    input wire logic battery_node_below_recharge,
    input wire logic battery_node_overvoltage,
    input wire logic [1:0] cell_strap,
    input wire logic fast_charge_indicator_oe,
    input wire logic full_charge_indicator_oe,
    input wire logic fault_indicator_oe,
    input wire logic therm_hot_current_en,
    input wire logic therm_cold_current_en,
    input wire logic high_side_enable,
    input wire logic divider_enable,
    input wire bcs_pkg::bcs_current_t charge_current,
    input wire logic [2:0] cell_count,
    input wire bcs_pkg::bcs_state_t charge_state
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // Antecedent conditions; s_fault_held and s_fast_reg exclude shutdown since it overrides all.
    sequence s_fault_held;
        charge_state == bcs_pkg::BCS_FAULT && shutdown_input;
    endsequence
    sequence s_charging;
        charge_state inside {bcs_pkg::BCS_PREQUAL, bcs_pkg::BCS_FAST,
            bcs_pkg::BCS_FULL, bcs_pkg::BCS_TOPOFF};
    endsequence
    sequence s_fast_reg;
        charge_state == bcs_pkg::BCS_FAST && battery_node_at_reg && shutdown_input &&
            !dropout_detect && !battery_node_overvoltage && charge_current == bcs_pkg::BCS_I_FULL;
    endsequence
    a_fault_latch: assert property (
        s_fault_held |=> charge_state == bcs_pkg::BCS_FAULT) else $error("Fault dropped.");
    a_fault_quiet: assert property (
        s_fault_held |-> charge_current == bcs_pkg::BCS_I_OFF && fault_indicator_oe &&
            !fast_charge_indicator_oe && !full_charge_indicator_oe) else $error("Fault out.");
    a_fast_lamp: assert property (
        charge_state == bcs_pkg::BCS_FAST && shutdown_input |-> fast_charge_indicator_oe &&
            !full_charge_indicator_oe) else $error("Fast lamp wrong.");
    a_full_lamp: assert property (
        charge_state == bcs_pkg::BCS_FULL && shutdown_input |-> full_charge_indicator_oe &&
            !fast_charge_indicator_oe) else $error("Full lamp wrong.");
    a_shutdown_input_float: assert property (
        !shutdown_input |-> !fast_charge_indicator_oe && !full_charge_indicator_oe &&
            !fault_indicator_oe && !high_side_enable && !divider_enable)
        else $error("Shutdown outputs wrong.");
    a_shutdown_input_exit: assert property (
        !shutdown_input |=> charge_state == bcs_pkg::BCS_RESET) else $error("No reset.");
    a_sense_alt: assert property (
        !(therm_hot_current_en && therm_cold_current_en)) else $error("Both currents on.");
    a_sense_pause: assert property (
        therm_hot_current_en || therm_cold_current_en |->
            charge_current == bcs_pkg::BCS_I_OFF) else $error("Charge during sample.");
    a_dropout_off: assert property (
        s_charging ##0 dropout_detect |=> charge_state == bcs_pkg::BCS_RESET)
        else $error("Dropout ignored.");
    a_cell_decode: assert property (
        !$past(reset) |-> cell_count == {1'b0, $past(cell_strap)} + 3'h1)
        else $error("Cell count wrong.");
    a_reg_to_full: assert property (
        s_fast_reg |=> charge_state == bcs_pkg::BCS_FULL) else $error("No full charge.");
    a_done_restart: assert property (
        charge_state == bcs_pkg::BCS_DONE && battery_node_below_recharge && shutdown_input
            |=> charge_state == bcs_pkg::BCS_RESET) else $error("No recharge.");
    a_done_idle: assert property (
        charge_state == bcs_pkg::BCS_DONE |-> charge_current == bcs_pkg::BCS_I_OFF)
        else $error("Current in done.");
endmodule : bcs_sequencer_monitor

/* File: verif/bcs_battery_model.sv */
/* Pack model: thermistor comparators and pulled-up indicator lamps.
   Assumes lamp bits ordered fault, full, fast. */
`timescale 1ns/1ps
module bcs_battery_model (
    input wire logic clk_sys,
    input wire logic too_hot,
    input wire logic too_cold,
    input wire logic hot_en,
    input wire logic cold_en,
    input wire logic [2:0] led_o,
    input wire logic [2:0] led_oe,
    output logic therm_hot_trip,
    output logic therm_cold_trip,
    output logic [2:0] led_level
);
    logic junk = 1'b0;
    // With no sense current the comparators read noise, so a stale answer never helps.
    always_ff @(posedge clk_sys) begin
        junk <= ~junk;
    end
    assign therm_hot_trip = hot_en ? too_hot : junk;
    assign therm_cold_trip = cold_en ? too_cold : ~junk;
    // A released line is pulled high by the lamp supply.
    assign led_level = (led_oe & led_o) | ~led_oe;
endmodule : bcs_battery_model

/* File: verif/tb.sv */
/* Self-checking bench for the charge sequencer.
   Assumes a one-cycle tick so that timer limits fit the run. */
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic reset, shutdown_input, dropout_detect, battery_node_above_uv, battery_node_at_reg;
    logic battery_node_below_recharge, battery_node_overvoltage, current_below_term, bias_ok;
    logic too_hot, too_cold, hot_trip, cold_trip, hot_en, cold_en, hs_en, div_en;
    logic [7:0] timer_cap_a, timer_cap_b;
    logic [7:0] seed = 8'h60;
    logic [1:0] cell_strap;
    logic [2:0] led_o, led_oe, led_level, cell_count;
    bcs_pkg::bcs_current_t charge_current;
    bcs_pkg::bcs_state_t charge_state;
    int n_errors = 0;
    int comparisons = 0;
    int n_hot = 0;
    int n_cold = 0;
    int k;
    int h0;
    int c0;
    bcs_sequencer #(.TICK_CYCLES(1)) u_bcs_sequencer (.clk_sys(clk_sys), .reset(reset),
        .shutdown_input(shutdown_input), .dropout_detect(dropout_detect),
        .battery_node_above_uv(battery_node_above_uv), .battery_node_at_reg(battery_node_at_reg),
        .battery_node_below_recharge(battery_node_below_recharge), .battery_node_overvoltage(battery_node_overvoltage),
        .current_below_term(current_below_term), .bias_ok(bias_ok),
        .therm_hot_trip(hot_trip), .therm_cold_trip(cold_trip), .timer_cap_a(timer_cap_a),
        .timer_cap_b(timer_cap_b), .cell_strap(cell_strap),
        .fast_charge_indicator_o(led_o[0]), .fast_charge_indicator_oe(led_oe[0]),
        .full_charge_indicator_o(led_o[1]), .full_charge_indicator_oe(led_oe[1]),
        .fault_indicator_o(led_o[2]), .fault_indicator_oe(led_oe[2]),
        .therm_hot_current_en(hot_en), .therm_cold_current_en(cold_en),
        .high_side_enable(hs_en), .divider_enable(div_en), .charge_current(charge_current),
        .cell_count(cell_count), .charge_state(charge_state));
    bcs_battery_model u_bcs_battery_model (.clk_sys(clk_sys), .too_hot(too_hot),
        .too_cold(too_cold), .hot_en(hot_en), .cold_en(cold_en), .led_o(led_o),
        .led_oe(led_oe), .therm_hot_trip(hot_trip), .therm_cold_trip(cold_trip),
        .led_level(led_level));
    // Clock of 20 ns period.
    always #10 clk_sys = ~clk_sys;
    // Sense pulses are counted to see that sampling really happens.
    always @(negedge clk_sys) begin
        n_hot += int'(hot_en === 1'b1);
        n_cold += int'(cold_en === 1'b1);
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    // Expected drive for each state; sampling pauses are avoided by the caller.
    function automatic logic [7:0] want_cur(input bcs_pkg::bcs_state_t s);
        case (s)
            bcs_pkg::BCS_PREQUAL: return 8'h01;
            bcs_pkg::BCS_FAST: return 8'h02;
            bcs_pkg::BCS_FULL, bcs_pkg::BCS_TOPOFF: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : want_cur
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    // Waits at least one falling edge, so a stimulus just launched has settled, then
    // compares drive and lamps once the state is reached outside any sample pause.
    task automatic go(input bcs_pkg::bcs_state_t s, input int lim);
        int i;
        i = 0;
        do begin
            @(negedge clk_sys);
            i++;
        end while (i < lim && (charge_state !== s || hot_en || cold_en));
        check(8'(charge_state), 8'(s));
        check(8'(charge_current), want_cur(s));
        check(8'(led_level[2:1]),
            {6'h00, s != bcs_pkg::BCS_FAULT, s != bcs_pkg::BCS_FULL});
        if (s != bcs_pkg::BCS_PREQUAL) begin
            check(8'(led_level[0]), 8'(s != bcs_pkg::BCS_FAST));
        end
    endtask : go
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // Main sequence of scenarios.
    initial begin
        {reset, shutdown_input, bias_ok} = 3'h7;
        {dropout_detect, battery_node_above_uv, battery_node_at_reg, battery_node_below_recharge} = 4'h0;
        {battery_node_overvoltage, current_below_term, too_hot, too_cold} = 4'h0;
        {timer_cap_a, timer_cap_b, cell_strap} = {8'h0A, 8'h0A, 2'h0};
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        for (k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            cell_strap <= 2'(k);
            @(posedge clk_sys);
            @(negedge clk_sys);
            check({5'h00, cell_count}, 8'(k + 1));
        end
        $display("strap decode done");
        // Every stimulus below is launched at a rising edge, checks happen on falling edges.
        @(posedge clk_sys);
        seed = lfsr(seed);
        timer_cap_a <= seed | 8'h10;
        seed = lfsr(seed);
        timer_cap_b <= seed | 8'h10;
        go(bcs_pkg::BCS_PREQUAL, 20);
        @(posedge clk_sys);
        battery_node_above_uv <= 1'b1;
        go(bcs_pkg::BCS_FAST, 20);
        for (k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            {too_cold, too_hot} <= k ? 2'h2 : 2'h1;
            h0 = n_hot;
            c0 = n_cold;
            repeat (1000) @(negedge clk_sys);
            check(8'(n_hot - h0 >= 2 && n_cold - c0 >= 2), 8'h01);
            check(8'(charge_state), 8'(bcs_pkg::BCS_FAST));
            check(8'(charge_current), 8'h00);
            @(posedge clk_sys);
            {too_cold, too_hot} <= 2'h0;
            repeat (1000) @(negedge clk_sys);
            go(bcs_pkg::BCS_FAST, 20);
        end
        $display("temperature suspend done");
        @(posedge clk_sys);
        battery_node_at_reg <= 1'b1;
        go(bcs_pkg::BCS_FULL, 20);
        @(posedge clk_sys);
        current_below_term <= 1'b1;
        go(bcs_pkg::BCS_TOPOFF, 20);
        // A zero timing setting gives a zero top-off period, so done follows at once.
        @(posedge clk_sys);
        timer_cap_a <= 8'h00;
        go(bcs_pkg::BCS_DONE, 20);
        check(8'(hs_en), 8'h00);
        @(posedge clk_sys);
        {battery_node_below_recharge, bias_ok} <= 2'h2;
        go(bcs_pkg::BCS_RESET, 20);
        @(posedge clk_sys);
        {battery_node_below_recharge, bias_ok} <= 2'h1;
        seed = lfsr(seed);
        timer_cap_a <= seed | 8'h10;
        go(bcs_pkg::BCS_TOPOFF, 20);
        @(posedge clk_sys);
        battery_node_overvoltage <= 1'b1;
        go(bcs_pkg::BCS_RESET, 20);
        @(posedge clk_sys);
        battery_node_overvoltage <= 1'b0;
        go(bcs_pkg::BCS_TOPOFF, 20);
        @(posedge clk_sys);
        dropout_detect <= 1'b1;
        go(bcs_pkg::BCS_RESET, 20);
        check(8'(hs_en), 8'h00);
        @(posedge clk_sys);
        shutdown_input <= 1'b0;
        go(bcs_pkg::BCS_RESET, 20);
        check({5'h00, led_level}, 8'h07);
        check({6'h00, hs_en, div_en}, 8'h00);
        $display("charge flow and shutdown done");
        @(posedge clk_sys);
        {battery_node_above_uv, battery_node_at_reg, current_below_term, dropout_detect} <= 4'h0;
        timer_cap_a <= 8'h01;
        shutdown_input <= 1'b1;
        go(bcs_pkg::BCS_PREQUAL, 20);
        go(bcs_pkg::BCS_FAULT, 50000);
        @(posedge clk_sys);
        battery_node_above_uv <= 1'b1;
        repeat (20) @(negedge clk_sys);
        go(bcs_pkg::BCS_FAULT, 1);
        @(posedge clk_sys);
        shutdown_input <= 1'b0;
        go(bcs_pkg::BCS_RESET, 20);
        $display("prequal fault done");
        finish_test();
    end
    // Watchdog sized above the longest expected run.
    initial begin
        #1400000;
        n_errors++;
        finish_test();
    end
endmodule : tb
bind bcs_sequencer bcs_sequencer_monitor u_bcs_sequencer_monitor (.clk_sys(clk_sys),
    .reset(reset), .shutdown_input(shutdown_input), .dropout_detect(dropout_detect),
    .battery_node_at_reg(battery_node_at_reg), .battery_node_below_recharge(battery_node_below_recharge),
    .battery_node_overvoltage(battery_node_overvoltage), .cell_strap(cell_strap),
    .fast_charge_indicator_oe(fast_charge_indicator_oe),
    .full_charge_indicator_oe(full_charge_indicator_oe),
    .fault_indicator_oe(fault_indicator_oe), .therm_hot_current_en(therm_hot_current_en),
    .therm_cold_current_en(therm_cold_current_en), .high_side_enable(high_side_enable),
    .divider_enable(divider_enable), .charge_current(charge_current),
    .cell_count(cell_count), .charge_state(charge_state));
